// File: drive_option_strap_decoder.sv
`timescale 1ns/1ps
// Function
// - Auto spin strap shorted starts spindle at power-on
// - Spin strap open waits for START UNIT
// - Not ready except five commands until ready
// - Parity strap enables receive parity checking
// - Transmit parity always generated
// - Strap open uses mode page level bit
// - Strap shorted forces SCSI-1 behaviour
// - Narrow build takes three address straps
// - Wide build takes four address straps
// - Alone, slave, master supported; not master-control
// - Stand-alone neither drives nor locks sync
// - Slave locks to external sync only
// - Master drives sync and locks to it
// - Programmable offset from incoming sync
// - SDTR strap starts negotiation after resets
// - Host SDTR always answered
// - Unit attention strap shorted suppresses reporting
// - Write protect strap forces medium protection
// - Strap open lets software set protection
// - Medium unprotected by default
module drive_option_strap_decoder
  import drive_strap_pkg::*;
#(
  parameter int WIDE_BUS = 0,
  parameter int REV_PERIOD_US = 11111,
  parameter int OFS_W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire straps_t strap_n,
  input wire logic bus_reset,
  input wire logic sync_in,
  output logic sync_out,
  output logic sync_out_oe,
  input wire logic spindle_at_speed,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_opcode,
  output logic cmd_accept,
  output logic cmd_not_ready,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_parity,
  output logic rx_parity_err,
  input wire logic [7:0] tx_data,
  output logic tx_parity,
  input wire logic host_sdtr,
  output logic sdtr_start,
  output logic sdtr_answer,
  output logic spindle_motor_on,
  output logic [3:0] bus_id,
  output logic scsi1_mode,
  output logic parity_check_en,
  output logic unit_attn_en,
  output logic write_protect,
  output logic spindle_lock_en,
  output logic spindle_ref
);

  localparam int REV_CYCLES = REV_PERIOD_US * CLK_MHZ;
  localparam int REV_W = $clog2(REV_CYCLES + 1);

  // Pin synchronisers
  straps_t strap_m_ff, strap_s_ff;
  logic brst_m_ff, brst_s_ff, brst_d_ff;
  logic sync_m_ff, sync_s_ff, sync_d_ff;

  // Strap capture state
  straps_t straps_ff;
  logic pend_ff, por_ff;
  logic [1:0] settle_ff;
  logic sampled_ff;

  // Software registers
  logic wp_sw_ff, s1_sw_ff, sync_en_ff;
  sync_mode_t mode_ff;
  logic [OFS_W-1:0] ofs_ff;
  logic perr_ff;

  // Behaviour state
  logic spin_ff;
  logic [REV_W-1:0] rev_cnt_ff;
  logic mpulse_ff;
  logic [OFS_W-1:0] dly_cnt_ff;
  logic dly_run_ff;

  // Synchronise straps, bus reset and sync input
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_m_ff <= STRAPS_RST;
      strap_s_ff <= STRAPS_RST;
      brst_m_ff <= 1'b0;
      brst_s_ff <= 1'b0;
      brst_d_ff <= 1'b0;
      sync_m_ff <= 1'b0;
      sync_s_ff <= 1'b0;
      sync_d_ff <= 1'b0;
    end else begin
      strap_m_ff <= ~strap_n;
      strap_s_ff <= strap_m_ff;
      brst_m_ff <= bus_reset;
      brst_s_ff <= brst_m_ff;
      brst_d_ff <= brst_s_ff;
      sync_m_ff <= sync_in;
      sync_s_ff <= sync_m_ff;
      sync_d_ff <= sync_s_ff;
    end
  end

  // Sampling requests: power-on and every bus reset
  logic brst_rise, settled, take;
  assign brst_rise = brst_s_ff & ~brst_d_ff;
  assign settled = (settle_ff == SETTLE_CYCLES);
  assign take = pend_ff & settled & ~brst_s_ff;

  // Hold a pending sample until the synchronisers have settled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_ff <= 1'b1;
      settle_ff <= 2'h0;
    end else if (brst_rise) begin
      pend_ff <= 1'b1;
      settle_ff <= 2'h0;
    end else if (take) begin
      pend_ff <= 1'b0;
    end else if (!settled) begin
      settle_ff <= settle_ff + 2'h1;
    end
  end

  // Latch straps; shorted pin reads asserted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      straps_ff <= STRAPS_RST;
      por_ff <= 1'b1;
      sampled_ff <= 1'b0;
    end else begin
      sampled_ff <= take;
      if (take) begin
        straps_ff <= strap_s_ff;
        por_ff <= 1'b0;
      end
    end
  end

  // Bus identifier width follows the build
  assign bus_id = (WIDE_BUS != 0) ? straps_ff.addr :
                  {1'b0, straps_ff.addr[2:0]};

  // Decoded options
  assign parity_check_en = straps_ff.parity;
  assign unit_attn_en = ~straps_ff.ua_off;
  assign scsi1_mode = straps_ff.scsi1 | s1_sw_ff;
  assign write_protect = straps_ff.wp | wp_sw_ff;

  // APB decode
  logic setup, wr_en;
  logic hit_ctrl, hit_sync, hit_stat, hit_any;
  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pwrite;
  assign hit_ctrl = (paddr == CTRL_OFS);
  assign hit_sync = (paddr == SYNC_OFS);
  assign hit_stat = (paddr == STAT_OFS);
  assign hit_any = hit_ctrl | hit_sync | hit_stat;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit_any;

  // Write decode of the control fields
  sync_mode_t wr_mode;
  logic wr_ctrl, start_req, stop_req, perr_clr;
  assign wr_ctrl = wr_en & hit_ctrl;
  assign wr_mode = sync_mode_t'(pwdata[CTRL_MODE_LSB +: 2]);
  assign start_req = wr_ctrl & pwdata[CTRL_START_BIT];
  assign stop_req = wr_ctrl & pwdata[CTRL_STOP_BIT];
  assign perr_clr = wr_en & hit_stat & pwdata[STAT_PERR_BIT];

  // Control and offset registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_sw_ff <= CTRL_WP_RST;
      s1_sw_ff <= CTRL_S1_RST;
      sync_en_ff <= CTRL_SYNC_EN_RST;
      mode_ff <= SYNC_ALONE;
      ofs_ff <= OFS_W'(SYNC_OFS_RST);
    end else begin
      if (wr_ctrl) begin
        wp_sw_ff <= pwdata[CTRL_WP_BIT];
        s1_sw_ff <= pwdata[CTRL_S1_BIT];
        sync_en_ff <= pwdata[CTRL_SYNC_EN_BIT];
        if (wr_mode != SYNC_MCTRL) begin
          mode_ff <= wr_mode;
        end
      end
      if (wr_en && hit_sync) begin
        ofs_ff <= pwdata[OFS_W-1:0];
      end
    end
  end

  // Read data mux
  logic [31:0] rd_ctrl, rd_sync, rd_stat, rd_mux;
  assign rd_ctrl = {25'h0, spin_ff, 1'b0, sync_en_ff, mode_ff, s1_sw_ff, wp_sw_ff};
  assign rd_sync = {{(32-OFS_W){1'b0}}, ofs_ff};
  assign rd_stat = {15'h0, perr_ff, 1'b0, spindle_at_speed, pend_ff,
                    write_protect, scsi1_mode, spin_ff, straps_ff};
  assign rd_mux = hit_ctrl ? rd_ctrl :
                  hit_sync ? rd_sync :
                  hit_stat ? rd_stat : 32'h0;

  // Read data captured in setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (setup && !pwrite) begin
      prdata <= rd_mux;
    end
  end

  // Command screening before the drive is ready
  logic exempt, drive_ready;
  assign drive_ready = spin_ff & spindle_at_speed;
  assign exempt = (cmd_opcode == OP_REQ_SENSE) | (cmd_opcode == OP_INQUIRY) |
                  (cmd_opcode == OP_RESERVE) | (cmd_opcode == OP_RELEASE) |
                  (cmd_opcode == OP_START_UNIT);
  logic host_start;
  assign host_start = cmd_valid & (cmd_opcode == OP_START_UNIT);

  // Registered accept/reject verdict, one cycle after cmd_valid
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_accept <= 1'b0;
      cmd_not_ready <= 1'b0;
    end else begin
      cmd_accept <= cmd_valid & (drive_ready | exempt);
      cmd_not_ready <= cmd_valid & ~drive_ready & ~exempt;
    end
  end

  // Spindle motor: auto start at power-on, else START UNIT
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      spin_ff <= 1'b0;
    end else if (take && por_ff && strap_s_ff.auto_spin) begin
      spin_ff <= 1'b1;
    end else if (host_start || start_req) begin
      spin_ff <= 1'b1;
    end else if (stop_req) begin
      spin_ff <= 1'b0;
    end
  end
  assign spindle_motor_on = spin_ff;

  // Receive parity check (odd parity) with sticky error flag
  logic rx_bad;
  assign rx_bad = rx_valid & parity_check_en & ~(^{rx_data, rx_parity});

  // Error flag: set wins over software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      perr_ff <= 1'b0;
      rx_parity_err <= 1'b0;
    end else begin
      rx_parity_err <= rx_bad;
      if (rx_bad) begin
        perr_ff <= 1'b1;
      end else if (perr_clr) begin
        perr_ff <= 1'b0;
      end
    end
  end

  // Transmit parity generated regardless of strap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_parity <= 1'b1;
    end else begin
      tx_parity <= ~(^tx_data);
    end
  end

  // Negotiation start after each sample; host request always answered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sdtr_start <= 1'b0;
      sdtr_answer <= 1'b0;
    end else begin
      sdtr_start <= sampled_ff & straps_ff.sdtr;
      sdtr_answer <= host_sdtr;
    end
  end

  // Effective routing; disabled sync behaves as stand-alone
  sync_mode_t eff_mode;
  assign eff_mode = sync_en_ff ? mode_ff : SYNC_ALONE;

  // Master revolution timer
  logic rev_end;
  assign rev_end = (rev_cnt_ff == REV_W'(REV_CYCLES - 1));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rev_cnt_ff <= '0;
      mpulse_ff <= 1'b0;
    end else begin
      mpulse_ff <= 1'b0;
      if (eff_mode != SYNC_MASTER) begin
        rev_cnt_ff <= '0;
      end else if (rev_end) begin
        rev_cnt_ff <= '0;
        mpulse_ff <= 1'b1;
      end else begin
        rev_cnt_ff <= rev_cnt_ff + REV_W'(1);
      end
    end
  end

  // Reference source by mode
  logic ext_edge, ref_src;
  assign ext_edge = sync_s_ff & ~sync_d_ff;
  always_comb begin
    case (eff_mode)
      SYNC_SLAVE: ref_src = ext_edge;
      SYNC_MASTER: ref_src = mpulse_ff;
      SYNC_ALONE: ref_src = 1'b0;
      default: ref_src = 1'b0;
    endcase
  end

  // Pin drive and lock enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_out <= 1'b0;
      sync_out_oe <= 1'b0;
      spindle_lock_en <= 1'b0;
    end else begin
      sync_out <= mpulse_ff & (eff_mode == SYNC_MASTER);
      sync_out_oe <= (eff_mode == SYNC_MASTER);
      spindle_lock_en <= (eff_mode == SYNC_SLAVE) | (eff_mode == SYNC_MASTER);
    end
  end

  // Positional offset: spindle_ref pulses ofs_ff + 2 cycles after the reference pulse
  logic dly_hit;
  assign dly_hit = dly_run_ff & (dly_cnt_ff == '0);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dly_cnt_ff <= '0;
      dly_run_ff <= 1'b0;
      spindle_ref <= 1'b0;
    end else begin
      spindle_ref <= 1'b0;
      if (ref_src) begin
        dly_cnt_ff <= ofs_ff;
        dly_run_ff <= 1'b1;
      end else if (dly_hit) begin
        dly_run_ff <= 1'b0;
        spindle_ref <= 1'b1;
      end else if (dly_run_ff) begin
        dly_cnt_ff <= dly_cnt_ff - OFS_W'(1);
      end
    end
  end

endmodule

// File: drive_option_strap_decoder_test.sv
`timescale 1ns/1ps
module drive_option_strap_decoder_test;
  import drive_strap_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, lfsr = 32'hb66cc8f2;
  logic pready, pslverr, bus_reset, sync_in, spindle_at_speed;
  straps_t strap_n;
  logic [7:0] tx_data, op;
  logic cmd_valid, rx_valid, rx_parity, host_sdtr, sync_out, sync_out_oe, sdtr_start, sdtr_answer;
  logic [7:0] cmd_opcode, rx_data;
  logic cmd_accept, cmd_not_ready, rx_parity_err, tx_parity, spindle_motor_on, scsi1_mode;
  logic parity_check_en, unit_attn_en, write_protect, spindle_lock_en, spindle_ref;
  logic [3:0] bus_id;
  logic [31:0] exp_rd[$];
  logic [1:0] exp_cmd[$];
  logic [7:0] exempt[4] = '{OP_REQ_SENSE, OP_INQUIRY, OP_RESERVE, OP_RELEASE};
  int errors = 0, total_checks = 0, n, pulses;
  always #4 pclk = ~pclk;
  drive_option_strap_decoder #(.REV_PERIOD_US(1)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .strap_n(strap_n), .bus_reset(bus_reset), .sync_in(sync_in), .sync_out(sync_out),
    .sync_out_oe(sync_out_oe), .spindle_at_speed(spindle_at_speed), .cmd_valid(cmd_valid),
    .cmd_opcode(cmd_opcode), .cmd_accept(cmd_accept), .cmd_not_ready(cmd_not_ready), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_parity(rx_parity), .rx_parity_err(rx_parity_err), .tx_data(tx_data),
    .tx_parity(tx_parity), .host_sdtr(host_sdtr), .sdtr_start(sdtr_start), .sdtr_answer(sdtr_answer),
    .spindle_motor_on(spindle_motor_on), .bus_id(bus_id), .scsi1_mode(scsi1_mode),
    .parity_check_en(parity_check_en), .unit_attn_en(unit_attn_en), .write_protect(write_protect),
    .spindle_lock_en(spindle_lock_en), .spindle_ref(spindle_ref));
  initiator_model u_host (.pclk(pclk), .cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_parity(rx_parity), .host_sdtr(host_sdtr));
  // Next state of the stimulus shift register
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    chk(exp_rd.size() + exp_cmd.size(), 0);
    if (errors == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // One APB transfer, held until pready is seen
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      chk(pready, 1'b1);
      tally_and_finish();
    end
  endtask
  // Counts sdtr_start pulses over a window of cycles
  task automatic count_sdtr(input int cycles);
    pulses = 0;
    repeat (cycles) begin
      @(negedge pclk);
      pulses += int'(sdtr_start);
    end
  endtask
  // Waits a bounded time for a pulse; runs out to the verdict
  task automatic wait_pulse(input logic sel);
    for (n = 0; n < 300 && (sel ? spindle_ref : sync_out) !== 1'b1; n++) @(negedge pclk);
    chk(n < 300, 1'b1);
    if (n >= 300) tally_and_finish();
  endtask
  // Compares read data and command answers against the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) chk(pslverr, !(paddr inside {CTRL_OFS, SYNC_OFS, STAT_OFS}));
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      chk(prdata, exp_rd.size() ? exp_rd.pop_front() : 32'hx);
    end
    if (cmd_accept !== 1'b0 || cmd_not_ready !== 1'b0) begin
      chk({cmd_accept, cmd_not_ready}, exp_cmd.size() ? exp_cmd.pop_front() : 2'bxx);
    end
  end
  initial begin
    #400000;
    chk(1'b0, 1'b1);
    tally_and_finish();
  end
  initial begin
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 12'h000;
    pwdata <= 32'h0;
    bus_reset <= 1'b0;
    sync_in <= 1'b0;
    spindle_at_speed <= 1'b0;
    strap_n <= 10'h2ba; // Parity and sdtr shorted, address 5
    tx_data <= 8'h00;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    count_sdtr(12);
    chk(pulses, 1);
    chk({bus_id, parity_check_en, unit_attn_en, write_protect, scsi1_mode}, 8'h5c);
    chk({spindle_motor_on, sync_out_oe, spindle_lock_en}, 3'b000);
    for (int i = 0; i < 16; i++) begin
      lfsr = lfsr_next(lfsr);
      op = (i < 4) ? exempt[i] : lfsr[7:0];
      if (op == OP_START_UNIT) op = 8'h00;
      tx_data <= lfsr[15:8];
      exp_cmd.push_back(op inside {OP_REQ_SENSE, OP_INQUIRY, OP_RESERVE, OP_RELEASE} ? 2'b10 : 2'b01);
      u_host.issue(op);
    end
    exp_cmd.push_back(2'b10);
    u_host.issue(OP_START_UNIT);
    exp_cmd.push_back(2'b01);
    u_host.issue(8'h28);
    spindle_at_speed <= 1'b1;
    exp_cmd.push_back(2'b10);
    u_host.issue(8'h28);
    u_host.send_byte(lfsr[7:0], 1'b1);
    @(negedge pclk);
    chk(rx_parity_err, 1'b1);
    chk(tx_parity, ~^tx_data);
    for (int i = 0; i < 8; i++) begin
      lfsr = lfsr_next(lfsr);
      u_host.send_byte(lfsr[7:0], lfsr[8]);
      @(negedge pclk);
      chk(rx_parity_err, lfsr[8]);
    end
    u_host.sdtr();
    @(negedge pclk);
    chk(sdtr_answer, 1'b1);
    apb(1'b1, CTRL_OFS, 32'h3);
    @(negedge pclk);
    chk({write_protect, scsi1_mode}, 2'b11);
    exp_rd.push_back(32'h15d45);
    apb(1'b0, STAT_OFS, 32'h0);
    apb(1'b1, STAT_OFS, 32'h10000);
    exp_rd.push_back(32'h05d45);
    apb(1'b0, STAT_OFS, 32'h0);
    apb(1'b1, CTRL_OFS, 32'h40);
    @(negedge pclk);
    chk(spindle_motor_on, 1'b0);
    apb(1'b1, CTRL_OFS, 32'h20);
    @(negedge pclk);
    chk(spindle_motor_on, 1'b1);
    apb(1'b1, CTRL_OFS, 32'hf);
    exp_rd.push_back(32'h43);
    apb(1'b0, CTRL_OFS, 32'h0);
    apb(1'b1, SYNC_OFS, 32'h5);
    exp_rd.push_back(32'h5);
    apb(1'b0, SYNC_OFS, 32'h0);
    exp_rd.push_back(32'h0);
    apb(1'b0, 12'h00c, 32'h0);
    apb(1'b1, CTRL_OFS, 32'h8);
    repeat (2) @(negedge pclk);
    chk({sync_out_oe, spindle_lock_en}, 2'b00);
    apb(1'b1, CTRL_OFS, 32'h18);
    repeat (2) @(negedge pclk);
    chk({sync_out_oe, spindle_lock_en}, 2'b11);
    wait_pulse(1'b0);
    wait_pulse(1'b1);
    apb(1'b1, CTRL_OFS, 32'h14);
    repeat (2) @(negedge pclk);
    chk({sync_out_oe, spindle_lock_en}, 2'b01);
    @(posedge pclk);
    sync_in <= 1'b1;
    repeat (4) @(posedge pclk);
    sync_in <= 1'b0;
    wait_pulse(1'b1);
    apb(1'b1, CTRL_OFS, 32'h0);
    strap_n <= 10'h30a;
    bus_reset <= 1'b1;
    repeat (4) @(posedge pclk);
    bus_reset <= 1'b0;
    count_sdtr(16);
    chk(pulses, 1);
    chk({write_protect, scsi1_mode, unit_attn_en, parity_check_en}, 4'b1100);
    u_host.send_byte(8'h01, 1'b1);
    @(negedge pclk);
    chk(rx_parity_err, 1'b0);
    @(posedge pclk);
    presetn <= 1'b0;
    strap_n <= 10'h00a;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (12) @(negedge pclk);
    chk({spindle_motor_on, sync_out_oe}, 2'b10);
    tally_and_finish();
  end
endmodule

// File: drive_strap_pkg.sv
package drive_strap_pkg;

  // Register offsets (byte addresses)
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] SYNC_OFS = 12'h004;
  localparam logic [11:0] STAT_OFS = 12'h008;

  // Control register field positions
  localparam int CTRL_WP_BIT = 0;
  localparam int CTRL_S1_BIT = 1;
  localparam int CTRL_MODE_LSB = 2;
  localparam int CTRL_SYNC_EN_BIT = 4;
  localparam int CTRL_START_BIT = 5;
  localparam int CTRL_STOP_BIT = 6;

  // Status register field positions
  localparam int STAT_PERR_BIT = 16;

  // Reset values
  localparam logic CTRL_WP_RST = 1'b0;
  localparam logic CTRL_S1_RST = 1'b0;
  localparam logic CTRL_SYNC_EN_RST = 1'b0;
  localparam logic [15:0] SYNC_OFS_RST = 16'h0000;

  // Cycles the pin synchronisers need before straps are trusted
  localparam logic [1:0] SETTLE_CYCLES = 2'h3;
  localparam int CLK_MHZ = 125;

  // Command opcodes honoured before the drive is ready
  localparam logic [7:0] OP_REQ_SENSE = 8'h03;
  localparam logic [7:0] OP_INQUIRY = 8'h12;
  localparam logic [7:0] OP_RESERVE = 8'h16;
  localparam logic [7:0] OP_RELEASE = 8'h17;
  localparam logic [7:0] OP_START_UNIT = 8'h1b;

  // Spindle synchronisation modes
  typedef enum logic [1:0] {
    SYNC_ALONE = 2'b00,
    SYNC_SLAVE = 2'b01,
    SYNC_MASTER = 2'b10,
    SYNC_MCTRL = 2'b11
  } sync_mode_t;

  // Option straps, asserted = jumper shorted
  typedef struct packed {
    logic auto_spin;
    logic parity;
    logic scsi1;
    logic sdtr;
    logic ua_off;
    logic wp;
    logic [3:0] addr;
  } straps_t;

  localparam straps_t STRAPS_RST = '0;

endpackage

// File: initiator_model.sv
`timescale 1ns/1ps
module initiator_model (
  input wire logic pclk,
  output logic cmd_valid,
  output logic [7:0] cmd_opcode,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_parity,
  output logic host_sdtr
);
  // Idle levels before the first request
  initial begin
    cmd_valid <= 1'b0;
    cmd_opcode <= 8'h00;
    rx_valid <= 1'b0;
    rx_data <= 8'h00;
    rx_parity <= 1'b1;
    host_sdtr <= 1'b0;
  end
  // One command for one cycle; released opcode lines invert
  task automatic issue(input logic [7:0] op);
    @(posedge pclk);
    cmd_valid <= 1'b1;
    cmd_opcode <= op;
    @(posedge pclk);
    cmd_valid <= 1'b0;
    cmd_opcode <= ~op;
  endtask
  // One received byte with odd parity, or broken on request
  task automatic send_byte(input logic [7:0] d, input logic bad);
    @(posedge pclk);
    rx_valid <= 1'b1;
    rx_data <= d;
    rx_parity <= ~^d ^ bad;
    @(posedge pclk);
    rx_valid <= 1'b0;
    rx_data <= ~d;
  endtask
  // Host opens a transfer negotiation
  task automatic sdtr();
    @(posedge pclk);
    host_sdtr <= 1'b1;
    @(posedge pclk);
    host_sdtr <= 1'b0;
  endtask
endmodule

// File: strap_decoder_properties.sv
`timescale 1ns/1ps
module strap_decoder_checker
  import drive_strap_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] tx_data,
  input wire logic tx_parity,
  input wire logic host_sdtr,
  input wire logic sdtr_answer,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_opcode,
  input wire logic cmd_accept,
  input wire logic cmd_not_ready,
  input wire logic spindle_motor_on,
  input wire logic spindle_at_speed,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_parity,
  input wire logic rx_parity_err,
  input wire logic parity_check_en,
  input wire logic sync_out,
  input wire logic sync_out_oe,
  input wire logic spindle_lock_en
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Opcodes served before ready, and a received byte with even total parity
  wire exempt = cmd_opcode inside {OP_REQ_SENSE, OP_INQUIRY, OP_RESERVE, OP_RELEASE, OP_START_UNIT};
  wire bad_rx = rx_valid && parity_check_en && !(^{rx_data, rx_parity});
  a_cmd_one_answer: assert property (cmd_valid |=> cmd_accept != cmd_not_ready)
    else $error("command answer count wrong");
  a_exempt_runs: assert property (cmd_valid && exempt |=> cmd_accept)
    else $error("exempt command refused");
  a_not_ready: assert property (cmd_valid && !exempt && !(spindle_motor_on && spindle_at_speed) |=> cmd_not_ready)
    else $error("command run before ready");
  a_start_spins: assert property (cmd_valid && cmd_opcode == OP_START_UNIT |=> spindle_motor_on)
    else $error("start did not spin");
  a_parity_flag: assert property (bad_rx |=> rx_parity_err)
    else $error("parity error missed");
  a_parity_cause: assert property (rx_parity_err |-> $past(bad_rx))
    else $error("parity error without cause");
  a_tx_odd: assert property ($past(presetn) |-> tx_parity == ~^$past(tx_data))
    else $error("transmit parity wrong");
  a_sdtr_reply: assert property (host_sdtr |=> sdtr_answer)
    else $error("host sdtr unanswered");
  a_quiet_sync: assert property (!sync_out_oe |-> !sync_out)
    else $error("sync pulse while not master");
  a_master_locks: assert property (sync_out_oe |-> spindle_lock_en)
    else $error("master not locked");
endmodule
bind drive_option_strap_decoder strap_decoder_checker u_chk (.pclk(pclk), .presetn(presetn),
  .tx_data(tx_data), .tx_parity(tx_parity), .host_sdtr(host_sdtr), .sdtr_answer(sdtr_answer),
  .cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode), .cmd_accept(cmd_accept), .cmd_not_ready(cmd_not_ready),
  .spindle_motor_on(spindle_motor_on), .spindle_at_speed(spindle_at_speed), .rx_valid(rx_valid),
  .rx_data(rx_data), .rx_parity(rx_parity), .rx_parity_err(rx_parity_err),
  .parity_check_en(parity_check_en), .sync_out(sync_out), .sync_out_oe(sync_out_oe),
  .spindle_lock_en(spindle_lock_en));
